/* File: hdl/osc_map.svh */
// osc_map.svh: offsets, field positions, reset values and codes of the oscillator control block
// assumes inclusion by the top module; holds definitions only
//
// Contract
// - bit 7 unimplemented, reads zero
// - codes 1111..1011 give 16 MHz to 1 MHz
// - reset code 0111; lower codes down to 31 kHz
// - bit 2 unimplemented, reads zero
// - source field bits 1:0; code 01 reserved
// - source 1x selects internal oscillator block
// - source 00 selects configuration oscillator
// - reset clears source select field
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH
`define OSC_CTRL_OFFSET   12'h000
`define OSC_STATUS_OFFSET 12'h004
`define OSC_IFS_LSB       3
`define OSC_IFS_MSB       6
`define OSC_CSS_LSB       0
`define OSC_CSS_MSB       1
`define OSC_IFS_RESET     4'h7
`define OSC_CSS_RESET     2'h0
`define OSC_CSS_RESERVED  2'h1
`define OSC_AXI_OKAY      2'h0
`define OSC_AXI_SLVERR    2'h2
`endif

/* File: hdl/osc_pkg.sv */
// osc_pkg.sv: types of the oscillator control block
// assumes osc_map.svh on the include path
package osc_pkg;
  // clock source as seen by the clock tree
  typedef enum logic [1:0] {
    OSC_SRC_CONFIG   = 2'b00,
    OSC_SRC_INTERNAL = 2'b01,
    OSC_SRC_LOW      = 2'b10
  } osc_src_e;
  // decoded selection handed to the clock tree
  typedef struct packed {
    osc_src_e    source;
    logic        hf_osc;
    logic [8:0]  div_log2;
    logic [1:0]  cfg_osc;
  } osc_sel_s;
endpackage : osc_pkg

/* File: hdl/osc_freq_decode.sv */
// osc_freq_decode.sv: maps the frequency select code to oscillator and divider
// assumes a combinational caller; divider is a power of two of the 16 MHz block
`timescale 1ns/1ps
module osc_freq_decode (
  // code in
  input  wire logic [3:0] internal_freq_select,
  // decode out
  output logic             hf_osc,
  output logic [3:0]       div_log2,
  output logic             low_osc
);
  // 1111 -> /1 .. 1000 -> /128 of the high-freq block
  wire       upper_half = internal_freq_select[3];
  wire [3:0] up_div     = 4'hf - internal_freq_select;
  // 0111 -> 500 kHz (/32), 0110 -> /64, 0101 -> /128, 0100 -> /256, 001x -> /512
  wire [3:0] lo_div     = internal_freq_select[2] ? 4'hc - internal_freq_select : 4'h9;
  assign low_osc  = (internal_freq_select[3:1] == 3'b000);
  assign hf_osc   = upper_half;
  assign div_log2 = upper_half ? up_div : (low_osc ? 4'h0 : lo_div);
endmodule : osc_freq_decode

/* File: hdl/osc_ctrl_top.sv */
// osc_ctrl_top.sv: oscillator control register behind an AXI4-Lite slave
// assumes one 200 MHz clock; configuration oscillator select is a strap from outside the clock domain
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "osc_map.svh"
module osc_ctrl_top
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // axi4-lite write address
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // configuration and clock tree
  input  wire logic [1:0]  CONFIG_OSCILLATOR_SELECT,
  output osc_pkg::osc_sel_s CLOCK_SELECT
);
  import osc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] internal_freq_select;
  logic [1:0] clock_source_select;
  logic       aw_held;
  logic       w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;

  // one write at a time: hold each channel until both arrived
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  wire aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_fire  = S_AXI_WVALID && S_AXI_WREADY;
  wire have_aw = aw_held || aw_fire;
  wire have_w  = w_held || w_fire;
  wire do_write = have_aw && have_w;
  wire [11:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
  wire [31:0] wr_data = w_held ? w_data : S_AXI_WDATA;
  wire        wr_lane = w_held ? w_lane0 : S_AXI_WSTRB[0];
  wire wr_ctrl = (wr_addr == `OSC_CTRL_OFFSET);
  wire wr_stat = (wr_addr == `OSC_STATUS_OFFSET);
  // only byte lane 0 carries the register; bits 7 and 2 are dropped
  wire [3:0] next_ifs = wr_data[`OSC_IFS_MSB:`OSC_IFS_LSB];
  wire [1:0] next_css = wr_data[`OSC_CSS_MSB:`OSC_CSS_LSB];
  wire ctrl_load = do_write && wr_ctrl && wr_lane;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_fire && !do_write) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_fire && !do_write) begin
        w_held  <= 1'b1;
        w_data  <= S_AXI_WDATA;
        w_lane0 <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields; reset defaults 500 kHz and configuration source
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      internal_freq_select <= `OSC_IFS_RESET;
      clock_source_select  <= `OSC_CSS_RESET;
    end else if (ctrl_load) begin
      internal_freq_select <= next_ifs;
      clock_source_select  <= next_css;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `OSC_AXI_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (wr_ctrl || wr_stat) ? `OSC_AXI_OKAY : `OSC_AXI_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side
  logic hf_osc;
  logic [3:0] div_log2;
  logic low_osc;

  osc_freq_decode u_decode (
    .internal_freq_select (internal_freq_select),
    .hf_osc               (hf_osc),
    .div_log2             (div_log2),
    .low_osc              (low_osc)
  );

  // reads of bits 7 and 2 return zero
  wire [31:0] ctrl_word = {24'h000000, 1'b0, internal_freq_select, 1'b0, clock_source_select};
  wire        src_int   = clock_source_select[1];
  // status: decoded source, oscillator and divider
  wire [31:0] stat_word = {20'h00000, div_log2, 2'b00, low_osc, hf_osc, 2'b00, src_int, !src_int};
  wire rd_ctrl = (S_AXI_ARADDR == `OSC_CTRL_OFFSET);
  wire rd_stat = (S_AXI_ARADDR == `OSC_STATUS_OFFSET);
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0000_0000);
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `OSC_AXI_OKAY;
    end else if (ar_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= (rd_ctrl || rd_stat) ? `OSC_AXI_OKAY : `OSC_AXI_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap crosses in through three flops; taken only once the last two agree,
  // so a half-changed strap reaches the clock tree only if it holds for two samples or more
  logic [1:0] cfg_meta;
  logic [1:0] cfg_sync;
  logic [1:0] cfg_last;
  logic [1:0] cfg_osc;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_meta <= 2'h0;
      cfg_sync <= 2'h0;
      cfg_last <= 2'h0;
      cfg_osc  <= 2'h0;
    end else begin
      cfg_meta <= CONFIG_OSCILLATOR_SELECT;
      cfg_sync <= cfg_meta;
      cfg_last <= cfg_sync;
      if (cfg_sync == cfg_last) begin
        cfg_osc <= cfg_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock tree selection; reserved 01 falls back to the configuration source
  osc_src_e next_src;
  assign next_src = !src_int ? OSC_SRC_CONFIG
                  : (low_osc ? OSC_SRC_LOW : OSC_SRC_INTERNAL);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CLOCK_SELECT <= '{source: OSC_SRC_CONFIG, hf_osc: 1'b0, div_log2: 9'h000, cfg_osc: 2'h0};
    end else begin
      CLOCK_SELECT.source   <= next_src;
      CLOCK_SELECT.hf_osc   <= hf_osc;
      CLOCK_SELECT.div_log2 <= {5'h00, div_log2};
      CLOCK_SELECT.cfg_osc  <= cfg_osc;
    end
  end
endmodule : osc_ctrl_top

/* File: sim/osc_ctrl_assertions.sv */
// osc_ctrl_assertions.sv: bus handshake and clock selection checks on osc_ctrl_top
// assumes osc_pkg compiled first; sees only the top module ports
`timescale 1ns/1ps
module osc_ctrl_assertions
  import osc_pkg::*;
(
  // clock, reset and axi4-lite
  input wire logic        SYS_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
  input wire logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY,
  input wire logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR,
  input wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, CONFIG_OSCILLATOR_SELECT,
  // clock tree
  input osc_pkg::osc_sel_s CLOCK_SELECT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic rd_ctrl;
  logic rd_bad;
  wire  wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  // remembers which place the pending read points at
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ctrl <= 1'b0;
      rd_bad  <= 1'b0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rd_ctrl <= S_AXI_ARADDR == 12'h000;
      rd_bad  <= S_AXI_ARADDR > 12'h004;
    end
  end
  // low codes excluded for the internal source: they move it to the low-frequency oscillator
  sequence ctrl_wr(logic s);
    wr_go && S_AXI_AWADDR == 12'h000 && S_AXI_WSTRB[0] && S_AXI_WDATA[1] == s
      && (S_AXI_WDATA[6:4] != 3'h0 || !s);
  endsequence
  b_resp_a: assert property (wr_go |=> S_AXI_BVALID) else $error("write answer late");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
  unimpl_zero_a: assert property (
    S_AXI_RVALID && rd_ctrl |-> S_AXI_RDATA[31:7] == 25'h0 && !S_AXI_RDATA[2]) else $error("spare bits set");
  bad_addr_a: assert property (S_AXI_RVALID && rd_bad |-> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answered");
  int_src_a: assert property (
    ctrl_wr(1'b1) |-> ##2 CLOCK_SELECT.source == OSC_SRC_INTERNAL) else $error("internal source missing");
  cfg_src_a: assert property (
    ctrl_wr(1'b0) |-> ##2 CLOCK_SELECT.source == OSC_SRC_CONFIG && CLOCK_SELECT.cfg_osc == CONFIG_OSCILLATOR_SELECT)
    else $error("config source missing");
  rst_src_a: assert property (
    $rose(RST_N) |=> CLOCK_SELECT.source == OSC_SRC_CONFIG && CLOCK_SELECT.div_log2 == 9'h5)
    else $error("reset selection wrong");
endmodule : osc_ctrl_assertions
////////////////////////////////////////////////////////////////////////////////
bind osc_ctrl_top osc_ctrl_assertions chk_u (.*);

/* File: sim/tb_oscillator_select_register.sv */
// tb_oscillator_select_register.sv: register and clock selection tests over axi4-lite
// assumes osc_pkg and the bound checker compiled first
`timescale 1ns/1ps
module tb_oscillator_select_register;
  import osc_pkg::*;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID;
  logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, CONFIG_OSCILLATOR_SELECT = 2'h2;
  osc_sel_s    CLOCK_SELECT;
  int          num_errors = 0, num_checks = 0;
  osc_ctrl_top dut_u (.*);
  always #2.5 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ready held off one cycle so the answer must stand
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b0;
    fork
      begin do @(posedge SYS_CLK); while (!S_AXI_AWREADY); S_AXI_AWVALID <= 1'b0; end
      begin do @(posedge SYS_CLK); while (!S_AXI_WREADY); S_AXI_WVALID <= 1'b0; end
    join
    @(posedge SYS_CLK);
    S_AXI_BREADY <= 1'b1;
    do @(posedge SYS_CLK); while (!S_AXI_BVALID);
    chk(S_AXI_BRESP, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b0;
    do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    @(posedge SYS_CLK);
    S_AXI_RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (!S_AXI_RVALID);
    chk(S_AXI_RDATA, ed);
    chk(S_AXI_RRESP, er);
  endtask : rd
  // log2 of the divider from 16 MHz for each code; the low-freq oscillator shows 0
  function automatic logic [8:0] div_of(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'hf: return 9'h0;
      4'he: return 9'h1;
      4'hd: return 9'h2;
      4'hc: return 9'h3;
      4'hb: return 9'h4;
      4'ha, 4'h7: return 9'h5;
      4'h9, 4'h6: return 9'h6;
      4'h8, 4'h5: return 9'h7;
      4'h4: return 9'h8;
      default: return 9'h9;
    endcase
  endfunction : div_of
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2000) @(posedge SYS_CLK);
    num_errors++;
    conclude();
  end
  initial begin
    logic [31:0] stat_exp;
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(12'h000, 32'h38, 2'h0);
    chk(CLOCK_SELECT.div_log2, 9'h5);
    for (int c = 0; c < 16; c++) begin
      wr(12'h000, 32'hffffff86 | (c << 3), 2'h0);
      rd(12'h000, 32'h2 | (c << 3), 2'h0);
      stat_exp = (32'(div_of(4'(c))) << 8) | (c < 2 ? 32'h20 : 32'h0) | (c >= 8 ? 32'h10 : 32'h0) | 32'h2;
      rd(12'h004, stat_exp, 2'h0);
      chk(CLOCK_SELECT.div_log2, div_of(4'(c)));
      chk(CLOCK_SELECT.hf_osc, c >= 8);
      chk(CLOCK_SELECT.source, c < 2 ? OSC_SRC_LOW : OSC_SRC_INTERNAL);
    end
    chk(CLOCK_SELECT.cfg_osc, 2'h2);
    wr(12'h000, 32'h1, 2'h0);
    rd(12'h000, 32'h1, 2'h0);
    rd(12'h004, 32'h21, 2'h0);
    chk(CLOCK_SELECT.source, OSC_SRC_CONFIG);
    wr(12'h008, 32'h7a, 2'h2);
    wr(12'h004, 32'h7a, 2'h0);
    rd(12'h010, 32'h0, 2'h2);
    S_AXI_WSTRB <= 4'he;
    wr(12'h000, 32'h7a, 2'h0);
    S_AXI_WSTRB <= 4'hf;
    rd(12'h000, 32'h1, 2'h0);
    wr(12'h000, 32'h7a, 2'h0);
    chk(CLOCK_SELECT.source, OSC_SRC_INTERNAL);
    chk(CLOCK_SELECT.div_log2, 9'h0);
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(12'h000, 32'h38, 2'h0);
    chk(CLOCK_SELECT.source, OSC_SRC_CONFIG);
    repeat (3) @(posedge SYS_CLK);
    chk(CLOCK_SELECT.cfg_osc, 2'h2);
    conclude();
  end
endmodule : tb_oscillator_select_register
